// ==== src/ppsq_regs.svh ====
// Timing counts, widths and a register bit for the power sequencer
`ifndef PPSQ_REGS_SVH
`define PPSQ_REGS_SVH
`define PPSQ_CLK_MHZ 40
`define PPSQ_SETTLE_US 100
`define PPSQ_SETTLE_CYC (`PPSQ_SETTLE_US * `PPSQ_CLK_MHZ)
`define PPSQ_OFF_DELAY_US 10
`define PPSQ_OFF_DELAY_CYC (`PPSQ_OFF_DELAY_US * `PPSQ_CLK_MHZ)
`define PPSQ_CNT_W 16
`define PPSQ_REG_W 4
`define PPSQ_RTC_REG_BIT 0
`endif

// ==== src/ppsq_pkg.sv ====
// Types for the power sequencer
package ppsq_pkg;
  typedef enum logic [2:0] {
    PPSQ_OFF = 3'b000,
    PPSQ_CHECK = 3'b001,
    PPSQ_TRICKLE = 3'b010,
    PPSQ_SETTLE = 3'b011,
    PPSQ_RUN = 3'b100,
    PPSQ_FAULT = 3'b101
  } ppsq_state_e;
endpackage

// ==== src/ppsq_top.sv ====
// Power-on/off and reset sequencer of the phone's power-management device
`timescale 1ns/1ps
`default_nettype none
`include "ppsq_regs.svh"
module ppsq_top
  import ppsq_pkg::*;
#(
  parameter int SETTLE_CYC = `PPSQ_SETTLE_CYC,
  parameter int OFF_CYC = `PPSQ_OFF_DELAY_CYC,
  parameter int REG_W = `PPSQ_REG_W
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  // Start sources from pins
  input wire logic BUTTON_START_INPUT_N_IN,
  input wire logic CONNECTOR_START_INPUT_N_IN,
  input wire logic ALARM_START_INPUT_IN,
  // Analog comparator results from pins
  input wire logic BATTERY_PRESENT_IN,
  input wire logic BATTERY_IN_LIMITS_IN,
  input wire logic CHARGER_DETECT_IN,
  input wire logic REGS_STABLE_IN,
  // Decoded host commands from the serial slave, same clock
  input wire logic CMD_REG_SEL_VALID_IN,
  input wire logic [REG_W-1:0] CMD_REG_SEL_IN,
  input wire logic CMD_SHUTDOWN_IN,
  input wire logic CMD_LED_VALID_IN,
  input wire logic CMD_LED_IN,
  input wire logic CMD_IRQ_MASK_VALID_IN,
  input wire logic CMD_IRQ_MASK_IN,
  // Power outputs
  output logic BUCK_EN_OUT,
  output logic [REG_W-1:0] LDO_EN_OUT,
  output logic SERIAL_EN_OUT,
  output logic RTC_SUPPLY_EN_OUT,
  output logic CHARGE_SWITCH_OUT,
  output logic TRICKLE_EN_OUT,
  output logic POWER_GOOD_RESET_N_OUT,
  // Indication
  output logic RED_LED_OUT,
  output logic IRQ_N_OUT,
  output logic [2:0] STATE_OUT
);
  localparam int CW = `PPSQ_CNT_W;
  localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYC - 1);
  localparam logic [CW-1:0] OFF_LAST = CW'(OFF_CYC - 1);

  // Two-flop synchronisers for every pin input
  logic [6:0] sync1;
  logic [6:0] sync2;
  always_ff @(posedge CLK_SYS_IN) begin
    sync1 <= {BUTTON_START_INPUT_N_IN, CONNECTOR_START_INPUT_N_IN, ALARM_START_INPUT_IN,
              BATTERY_PRESENT_IN, BATTERY_IN_LIMITS_IN, CHARGER_DETECT_IN, REGS_STABLE_IN};
    sync2 <= sync1;
  end
  logic btn_n, con_n, alarm, batt, in_lim, chg, stable;
  assign {btn_n, con_n, alarm, batt, in_lim, chg, stable} = sync2;

  logic start_req;
  assign start_req = !btn_n || !con_n || alarm;

  ppsq_state_e state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic [REG_W-1:0] reg_sel, next_reg_sel;
  logic led, next_led;
  logic mask, next_mask;
  logic rst_n, next_rst_n;
  logic trickle, next_trickle;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_reg_sel = reg_sel;
    next_led = led;
    next_mask = mask;
    next_rst_n = rst_n;
    next_trickle = 1'b0;
    unique case (state)
      PPSQ_OFF: begin
        next_rst_n = 1'b0;
        next_led = 1'b0;
        if (batt && (start_req || chg)) begin
          next_state = PPSQ_CHECK;
        end
      end
      PPSQ_CHECK: begin
        if (in_lim) begin
          next_state = PPSQ_SETTLE;
          next_cnt = '0;
          next_reg_sel = '1;
          next_mask = 1'b0;
        end else if (chg) begin
          next_state = PPSQ_TRICKLE;
          next_led = 1'b1;
        end else begin
          next_state = PPSQ_OFF;
        end
      end
      PPSQ_TRICKLE: begin
        next_led = 1'b1;
        if (!chg || !batt) begin
          next_state = PPSQ_OFF;
        end else if (in_lim) begin
          next_state = PPSQ_CHECK;
        end
      end
      PPSQ_SETTLE: begin
        // Reset stays low until the regulators report stable and the settle time ran out
        if (!in_lim) begin
          next_state = PPSQ_FAULT;
          next_cnt = '0;
        end else if (cnt != SETTLE_LAST) begin
          next_cnt = CW'(cnt + 1'b1);
        end else if (stable) begin
          next_rst_n = 1'b1;
          next_state = PPSQ_RUN;
          next_led = 1'b0;
        end
      end
      PPSQ_RUN: begin
        // Start inputs cannot restart the sequence here; the button only pulls IRQ_N_OUT low unless masked
        if (CMD_REG_SEL_VALID_IN) begin
          next_reg_sel = CMD_REG_SEL_IN;
        end
        if (CMD_LED_VALID_IN) begin
          next_led = CMD_LED_IN;
        end
        if (CMD_IRQ_MASK_VALID_IN) begin
          next_mask = CMD_IRQ_MASK_IN;
        end
        if (!in_lim) begin
          next_rst_n = 1'b0;
          next_state = PPSQ_FAULT;
          next_cnt = '0;
        end else if (CMD_SHUTDOWN_IN) begin
          next_rst_n = 1'b0;
          next_state = PPSQ_FAULT;
          next_cnt = '0;
        end
      end
      PPSQ_FAULT: begin
        // Host held in reset for a while before buck and serial drop (LDOs go off as reset asserts), so it never runs on a dying supply
        next_rst_n = 1'b0;
        if (cnt != OFF_LAST) begin
          next_cnt = CW'(cnt + 1'b1);
        end else begin
          next_state = PPSQ_OFF;
          next_cnt = '0;
        end
      end
      default: begin
        next_state = PPSQ_OFF;
      end
    endcase
    // Taken from the next state so the pin moves on the same edge as the state
    next_trickle = (next_state == PPSQ_TRICKLE);
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      state <= PPSQ_OFF;
      cnt <= '0;
      reg_sel <= '0;
      led <= 1'b0;
      mask <= 1'b0;
      rst_n <= 1'b0;
      trickle <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      reg_sel <= next_reg_sel;
      led <= next_led;
      mask <= next_mask;
      rst_n <= next_rst_n;
      trickle <= next_trickle;
    end
  end

  // Next output values; every pin comes straight from a flop
  logic on_next;
  logic next_buck, next_serial, next_rtc, next_cs;
  logic next_trk_out, next_rst_out, next_led_out, next_irq_n;
  logic [REG_W-1:0] next_ldo;
  logic [2:0] next_state_out;
  always_comb begin
    on_next = (next_state == PPSQ_SETTLE) || (next_state == PPSQ_RUN) ||
              (next_state == PPSQ_FAULT);
    // Serial stays up through the fault hold and buck until its last cycle, so the host sees its reset first
    next_buck = on_next && (next_state != PPSQ_FAULT || next_cnt != OFF_LAST);
    next_ldo = (on_next && next_state != PPSQ_FAULT) ? next_reg_sel : '0;
    next_serial = on_next;
    next_rtc = batt;
    // Switch opens while trickling so only the small current flows
    next_cs = chg && batt && !next_trickle;
    next_trk_out = next_trickle;
    next_rst_out = next_rst_n;
    next_led_out = next_led;
    next_irq_n = !(next_state == PPSQ_RUN && !btn_n && !next_mask);
    next_state_out = next_state;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      BUCK_EN_OUT <= 1'b0;
      LDO_EN_OUT <= '0;
      SERIAL_EN_OUT <= 1'b0;
      RTC_SUPPLY_EN_OUT <= 1'b0;
      CHARGE_SWITCH_OUT <= 1'b0;
      TRICKLE_EN_OUT <= 1'b0;
      POWER_GOOD_RESET_N_OUT <= 1'b0;
      RED_LED_OUT <= 1'b0;
      IRQ_N_OUT <= 1'b1;
      STATE_OUT <= 3'h0;
    end else begin
      BUCK_EN_OUT <= next_buck;
      LDO_EN_OUT <= next_ldo;
      SERIAL_EN_OUT <= next_serial;
      RTC_SUPPLY_EN_OUT <= next_rtc;
      CHARGE_SWITCH_OUT <= next_cs;
      TRICKLE_EN_OUT <= next_trk_out;
      POWER_GOOD_RESET_N_OUT <= next_rst_out;
      RED_LED_OUT <= next_led_out;
      IRQ_N_OUT <= next_irq_n;
      STATE_OUT <= next_state_out;
    end
  end

  // Checks
  a_reset_before_off: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_RUN && !in_lim) |=> !rst_n && state == PPSQ_FAULT)
    else $error("reset not asserted on battery fault");
  a_rst_low_settle: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_SETTLE) |-> !rst_n)
    else $error("reset released before settle");
  a_rtc_follows: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    batt |=> RTC_SUPPLY_EN_OUT)
    else $error("rtc supply off with battery");
  a_no_restart_run: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_RUN && in_lim && !CMD_SHUTDOWN_IN) |=> state == PPSQ_RUN)
    else $error("run disturbed");
  a_trickle_led: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_TRICKLE) |-> trickle && TRICKLE_EN_OUT && RED_LED_OUT)
    else $error("trickle without led");
  a_start_check: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_OFF && batt && start_req) |=> state == PPSQ_CHECK)
    else $error("start ignored");
  a_check_power: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_CHECK && in_lim) |=> BUCK_EN_OUT && SERIAL_EN_OUT)
    else $error("regulators not enabled");
  a_led_cmd: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_RUN && in_lim && !CMD_SHUTDOWN_IN && CMD_LED_VALID_IN)
      |=> RED_LED_OUT == $past(CMD_LED_IN))
    else $error("led command lost");
  // Power-down and release each take two steps, so they are written as sequences
  sequence s_run_exit;
    (state == PPSQ_RUN && (!in_lim || CMD_SHUTDOWN_IN)) ##1 (state == PPSQ_FAULT);
  endsequence
  sequence s_settle_done;
    (state == PPSQ_SETTLE && in_lim && cnt == SETTLE_LAST && stable) ##1 (state == PPSQ_RUN);
  endsequence
  a_fault_order: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    s_run_exit |-> !POWER_GOOD_RESET_N_OUT && BUCK_EN_OUT && SERIAL_EN_OUT)
    else $error("rails dropped before host reset");
  a_release_stable: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    s_settle_done |-> POWER_GOOD_RESET_N_OUT && BUCK_EN_OUT && LDO_EN_OUT == reg_sel)
    else $error("reset not released after settle");
  a_wait_stable: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_SETTLE && !stable) |=> !POWER_GOOD_RESET_N_OUT)
    else $error("reset released before regulators stable");
  a_fault_to_off: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_FAULT && cnt == OFF_LAST) |=> state == PPSQ_OFF && !BUCK_EN_OUT &&
      !SERIAL_EN_OUT && LDO_EN_OUT == '0 && !POWER_GOOD_RESET_N_OUT)
    else $error("regulators left on after fault hold");
  a_check_trickle: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_CHECK && !in_lim && chg) |=> state == PPSQ_TRICKLE &&
      TRICKLE_EN_OUT && RED_LED_OUT && !BUCK_EN_OUT && !CHARGE_SWITCH_OUT)
    else $error("trickle not entered on low battery");
  a_charger_start: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_OFF && batt && chg) |=> state == PPSQ_CHECK)
    else $error("charger start ignored");
  a_sel_cmd: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_RUN && in_lim && !CMD_SHUTDOWN_IN && CMD_REG_SEL_VALID_IN)
      |=> LDO_EN_OUT == $past(CMD_REG_SEL_IN))
    else $error("regulator select lost");
  a_irq_mask: assert property (
    @(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (state == PPSQ_RUN && mask) |-> IRQ_N_OUT)
    else $error("masked button raised interrupt");
endmodule // ppsq_top
`default_nettype wire

// ==== tb/ppsq_host_model.sv ====
// Host processor model issuing decoded serial commands
`timescale 1ns/1ps
`default_nettype none
module ppsq_host_model (
  // Clock
  input wire logic clk_in,
  // Commands
  output logic sel_valid_out,
  output logic [3:0] sel_out,
  output logic shutdown_out,
  output logic led_valid_out,
  output logic led_out,
  output logic mask_valid_out,
  output logic mask_out
);
  initial begin
    {sel_valid_out, sel_out, shutdown_out, led_valid_out, led_out, mask_valid_out, mask_out} = '0;
  end
  // Kind 0 select, 1 led, 2 mask, 3 shutdown; data is garbled outside the pulse
  task automatic send(input int kind, input logic [3:0] val);
    @(posedge clk_in);
    #1;
    {sel_out, led_out, mask_out} = {val, val[0], val[0]};
    sel_valid_out = (kind == 0);
    led_valid_out = (kind == 1);
    mask_valid_out = (kind == 2);
    shutdown_out = (kind == 3);
    @(posedge clk_in);
    #1;
    {sel_valid_out, led_valid_out, mask_valid_out, shutdown_out} = '0;
    {sel_out, led_out, mask_out} = {~val, ~val[0], ~val[0]};
  endtask
endmodule // ppsq_host_model
`default_nettype wire

// ==== tb/ppsq_top_tb.sv ====
// Self-checking bench of the power sequencer
`timescale 1ns/1ps
`default_nettype none
module ppsq_top_tb;
  import ppsq_pkg::*;
  // Short counts keep the run brief
  localparam int SETTLE = 8;
  localparam int OFFC = 4;
  logic clk = 1'b0, srst = 1'b1, btn_n = 1'b1, con_n = 1'b1, alarm = 1'b0;
  logic bat = 1'b1, lim = 1'b1, chg = 1'b0, stable = 1'b1;
  logic sv, sd, lv, ld, mv, md, buck, ser, rtc, cs, trk, rst_n, led, irq_n;
  logic [3:0] sel, ldo;
  logic [2:0] st;
  int miscompares = 0, samples_checked = 0;
  ppsq_top #(.SETTLE_CYC(SETTLE), .OFF_CYC(OFFC), .REG_W(4)) i_dut (
    .CLK_SYS_IN(clk), .SRST_IN(srst), .BUTTON_START_INPUT_N_IN(btn_n),
    .CONNECTOR_START_INPUT_N_IN(con_n), .ALARM_START_INPUT_IN(alarm),
    .BATTERY_PRESENT_IN(bat), .BATTERY_IN_LIMITS_IN(lim), .CHARGER_DETECT_IN(chg),
    .REGS_STABLE_IN(stable), .CMD_REG_SEL_VALID_IN(sv), .CMD_REG_SEL_IN(sel),
    .CMD_SHUTDOWN_IN(sd), .CMD_LED_VALID_IN(lv), .CMD_LED_IN(ld),
    .CMD_IRQ_MASK_VALID_IN(mv), .CMD_IRQ_MASK_IN(md), .BUCK_EN_OUT(buck),
    .LDO_EN_OUT(ldo), .SERIAL_EN_OUT(ser), .RTC_SUPPLY_EN_OUT(rtc),
    .CHARGE_SWITCH_OUT(cs), .TRICKLE_EN_OUT(trk), .POWER_GOOD_RESET_N_OUT(rst_n),
    .RED_LED_OUT(led), .IRQ_N_OUT(irq_n), .STATE_OUT(st));
  ppsq_host_model i_host (.clk_in(clk), .sel_valid_out(sv), .sel_out(sel),
    .shutdown_out(sd), .led_valid_out(lv), .led_out(ld), .mask_valid_out(mv),
    .mask_out(md));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait, then the state itself is compared
  task automatic wait_st(input logic [2:0] exp);
    for (int i = 0; i < 200 && st !== exp; i++) cyc(1);
    chk(st, exp);
  endtask
  task automatic complete_run;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    cyc(3);
    srst = 1'b0;
    cyc(2);
    chk({st, rst_n, irq_n, buck, ser, ldo, rtc}, 12'h081);
    stable = 1'b0;
    btn_n = 1'b0;
    wait_st(PPSQ_SETTLE);
    chk({buck, ser, ldo, rst_n}, 12'h07E);
    cyc(SETTLE + 4);
    chk({st, rst_n}, {PPSQ_SETTLE, 1'b0});
    stable = 1'b1;
    wait_st(PPSQ_RUN);
    chk(rst_n, 1'b1);
    i_host.send(0, 4'h5);
    btn_n = 1'b1;
    cyc(4);
    chk({st, ldo}, {PPSQ_RUN, 4'h5});
    i_host.send(1, 4'h1);
    cyc(2);
    chk(led, 1'b1);
    i_host.send(1, 4'h0);
    btn_n = 1'b0;
    cyc(4);
    chk({st, irq_n, led}, {PPSQ_RUN, 2'b00});
    btn_n = 1'b1;
    i_host.send(2, 4'h1);
    {btn_n, con_n, alarm} = 3'b001;
    cyc(4);
    chk({st, irq_n, ldo}, {PPSQ_RUN, 1'b1, 4'h5});
    {btn_n, con_n, alarm} = 3'b110;
    i_host.send(3, 4'h0);
    for (int s = 0; s < 2; s++) begin
      wait_st(PPSQ_FAULT);
      chk({rst_n, buck, ldo}, 12'h010);
      wait_st(PPSQ_OFF);
      chk({buck, ser, ldo, rtc}, 12'h001);
      lim = 1'b1;
      if (s == 0) con_n = 1'b0;
      else alarm = 1'b1;
      wait_st(PPSQ_RUN);
      chk({buck, ser, ldo, rst_n}, 12'h07F);
      {con_n, alarm} = 2'b10;
      if (s == 0) lim = 1'b0;
    end
    i_host.send(3, 4'h0);
    wait_st(PPSQ_OFF);
    lim = 1'b0;
    chg = 1'b1;
    wait_st(PPSQ_TRICKLE);
    chk({trk, led, cs, buck}, 12'h00C);
    lim = 1'b1;
    wait_st(PPSQ_RUN);
    chk({trk, cs, buck}, 12'h003);
    complete_run();
  end
  initial begin
    #(25 * 5000);
    miscompares++;
    complete_run();
  end
endmodule // ppsq_top_tb
`default_nettype wire
